//--- common/djr_pkg.sv
// Constants and types for the debug register access scan block.
// Assumes one system clock; the scan pins are asynchronous to it.
package djr_pkg;
    localparam int IR_W = 5;
    localparam int DR_W = 34;
    localparam int CNT_W = 6;
    localparam int IDX_W = 7;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;
    localparam logic [IR_W-1:0] IR_DBG = 5'h10;
    localparam logic [IR_W-1:0] IR_BYPASS = 5'h1f;
    localparam logic [1:0] IR_CAP_LOW = 2'h1;
    localparam logic [CNT_W-1:0] DR_LEN = 6'h22;
    localparam logic [DR_W-1:0] DR_ZERO = 34'h0_0000_0000;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_STAT = 4'h4;
    localparam int CTRL_LOCK = 0;
    localparam int STAT_ACTIVE = 0;
    localparam int STAT_PHASE = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_ERR = 3;
    localparam int STAT_PROT = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Request toward the service access bus
    typedef struct packed {
        logic valid;
        logic rnw;
        logic [IDX_W-1:0] index;
        logic [DATA_W-1:0] wdata;
    } djr_sab_req_t;

    // Completion from the service access bus
    typedef struct packed {
        logic done;
        logic err;
        logic [DATA_W-1:0] rdata;
    } djr_sab_rsp_t;

    // Test access port controller states
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } djr_tap_t;
endpackage : djr_pkg

//--- rtl/djr_top.sv
// Scan port with debug register access instruction, AXI4-Lite slave.
// Assumes tck/tms/tdi are asynchronous pins; bus side and fuse on aclk.
//
// How it works
// - Patterns shift rightmost character first
// - Address and data fields travel LSB first
// - Busy bit shows bus transfer outstanding
// - Error bit shows last transfer failed
// - Protected bit reflects restricted access state
// - Don't-care inputs ignored, outputs read zero
// - IR captures protected, error, busy, zero, one
// - Code 10000 selects debug register access
// - Data chain is 34 bits long
// - Selection starts in address phase
// - Phase toggles only on non-busy update
// - Address phase: direction then seven index bits
// - Truncated read data scans are tolerated
// - Read phase outputs data, busy, then error
// - Eight-bit address scans are accepted
// - Security fuse makes instruction unavailable
`timescale 1ns/1ps
module djr_top (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic tck, // Scan clock pin
    input wire logic tms, // Scan mode select pin
    input wire logic tdi, // Scan data in pin
    output logic tdo, // Scan data out
    output logic tdo_oe, // Scan data out enable
    input wire logic fuse_secure, // Security fuse programmed
    output djr_pkg::djr_sab_req_t sab_req, // Bus request
    input wire djr_pkg::djr_sab_rsp_t sab_rsp, // Bus completion
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [djr_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    output logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    input wire logic [djr_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp // Read response
);
    import djr_pkg::*;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic tck_d;
    djr_tap_t st;
    logic [IR_W-1:0] ir_sr;
    logic [DR_W-1:0] dr_sr;
    logic [CNT_W-1:0] dr_cnt;
    logic byp;
    logic dbg_active;
    logic data_phase;
    logic busy;
    logic err;
    logic prot;
    logic cur_rnw;
    logic [IDX_W-1:0] cur_idx;
    logic [DATA_W-1:0] rdata_q;
    logic ctrl_lock;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic [31:0] rd_val;
    logic [1:0] rd_resp;
    // Next controller state from tms
    function automatic djr_tap_t tap_next(input djr_tap_t s, input logic m);
        case (s)
            ST_TLR: tap_next = m ? ST_TLR : ST_RTI;
            ST_RTI: tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: tap_next = m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_next = m ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: tap_next = m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_RTI;
            default: tap_next = ST_TLR;
        endcase
    endfunction : tap_next
    // Right-justify a short scan so bit 0 is the first bit shifted in
    function automatic logic [DR_W-1:0] dr_align(input logic [DR_W-1:0] v,
                                                 input logic [CNT_W-1:0] n);
        dr_align = (n >= DR_LEN) ? v : v >> (DR_LEN - n);
    endfunction : dr_align
    // Pin synchronisers and scan clock edge detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            tck_d <= 1'b0;
        end else begin
            sync1 <= {tck, tms, tdi};
            sync2 <= sync1;
            tck_d <= sync2[2];
        end
    end
    // Decoded scan events
    wire tck_s = sync2[2];
    wire tms_s = sync2[1];
    wire tdi_s = sync2[0];
    wire tck_rise = tck_s & ~tck_d;
    wire tck_fall = ~tck_s & tck_d;
    wire cap_ir = tck_rise & (st == ST_CAP_IR);
    wire sh_ir = tck_rise & (st == ST_SH_IR);
    wire upd_ir = tck_rise & (st == ST_UPD_IR);
    wire cap_dr = tck_rise & (st == ST_CAP_DR);
    wire sh_dr = tck_rise & (st == ST_SH_DR);
    wire upd_dr = tck_rise & (st == ST_UPD_DR) & dbg_active;
    wire in_tlr = tck_rise & (st == ST_TLR);
    wire [DR_W-1:0] dr_al = dr_align(dr_sr, dr_cnt);
    wire rd_capture = data_phase & cur_rnw;
    wire launch_rd = upd_dr & ~busy & ~data_phase & dr_al[0];
    wire launch_wr = upd_dr & ~busy & data_phase & ~cur_rnw;
    wire launch = launch_rd | launch_wr;
    // Controller state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= ST_TLR;
        end else if (tck_rise) begin
            st <= tap_next(st, tms_s);
        end
    end
    // Instruction path; keeps shifting while protected so status stays visible
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ir_sr <= IR_BYPASS;
        end else if (cap_ir) begin
            ir_sr <= {prot, err, busy, IR_CAP_LOW};
        end else if (sh_ir) begin
            ir_sr <= {tdi_s, ir_sr[IR_W-1:1]};
        end
    end
    // Selection; protection makes the access instruction act as bypass
    always_ff @(posedge aclk) begin
        if (!aresetn || in_tlr || prot) begin
            dbg_active <= 1'b0;
        end else if (upd_ir) begin
            dbg_active <= (ir_sr == IR_DBG);
        end
    end
    // Data chain: 34-bit register or one-bit bypass
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dr_sr <= DR_ZERO;
            dr_cnt <= '0;
            byp <= 1'b0;
        end else if (cap_dr) begin
            dr_sr <= rd_capture ? {err, busy, rdata_q} : DR_ZERO;
            dr_cnt <= '0;
            byp <= 1'b0;
        end else if (sh_dr) begin
            dr_sr <= {tdi_s, dr_sr[DR_W-1:1]};
            dr_cnt <= (dr_cnt >= DR_LEN) ? dr_cnt : dr_cnt + 6'h1;
            byp <= tdi_s;
        end
    end
    // Phase tracking and latched address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_phase <= 1'b0;
            cur_rnw <= 1'b0;
            cur_idx <= '0;
        end else if (upd_ir) begin
            data_phase <= 1'b0;
        end else if (upd_dr && !busy) begin
            data_phase <= ~data_phase;
            if (!data_phase) begin
                cur_rnw <= dr_al[0];
                cur_idx <= dr_al[IDX_W:1];
            end
        end
    end
    // Bus transfer launch, busy, error and read data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sab_req <= '0;
            busy <= 1'b0;
            err <= 1'b0;
            rdata_q <= WORD_ZERO;
            prot <= 1'b0;
        end else begin
            prot <= fuse_secure | ctrl_lock;
            sab_req.valid <= launch;
            if (launch) begin
                sab_req.rnw <= launch_rd;
                sab_req.index <= launch_rd ? dr_al[IDX_W:1] : cur_idx;
                sab_req.wdata <= launch_rd ? WORD_ZERO : dr_al[DATA_W-1:0];
                busy <= 1'b1;
                err <= 1'b0;
            end else if (busy && sab_rsp.done) begin
                busy <= 1'b0;
                err <= sab_rsp.err;
                if (sab_req.rnw) begin
                    rdata_q <= sab_rsp.rdata;
                end
            end
        end
    end
    // Output pin updates on falling scan clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (st == ST_SH_IR) || (st == ST_SH_DR);
            tdo <= (st == ST_SH_IR) ? ir_sr[0] : (dbg_active ? dr_sr[0] : byp);
        end
    end
    // Register read decode
    wire ar_ctrl = (s_axi_araddr == OFF_CTRL);
    wire ar_stat = (s_axi_araddr == OFF_STAT);
    wire [31:0] ctrl_word = 32'(ctrl_lock) << CTRL_LOCK;
    wire [31:0] stat_word = (32'(dbg_active) << STAT_ACTIVE) | (32'(data_phase) << STAT_PHASE)
        | (32'(busy) << STAT_BUSY) | (32'(err) << STAT_ERR) | (32'(prot) << STAT_PROT);
    assign rd_val = ar_stat ? stat_word : (ar_ctrl ? ctrl_word : WORD_ZERO);
    assign rd_resp = (ar_ctrl || ar_stat) ? RESP_OKAY : RESP_SLVERR;
    // AXI4-Lite write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_q <= '0;
            wd_q <= WORD_ZERO;
            ws_q <= 4'h0;
            ctrl_lock <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_got & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_got & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q == OFF_CTRL || aw_q == OFF_STAT) ? RESP_OKAY : RESP_SLVERR;
                if (aw_q == OFF_CTRL && ws_q[0]) begin
                    ctrl_lock <= wd_q[CTRL_LOCK];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // AXI4-Lite read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= WORD_ZERO;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_resp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // Checks on the scan behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ir_capture;
        cap_ir && !prot |=> ir_sr == {1'b0, $past(err), $past(busy), IR_CAP_LOW};
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("bad IR capture");
    property p_select;
        upd_ir && !in_tlr && !prot && ir_sr == IR_DBG |=> dbg_active;
    endproperty
    a_select: assert property (p_select) else $error("code not selected");
    property p_secure;
        prot |=> !dbg_active;
    endproperty
    a_secure: assert property (p_secure) else $error("active while secure");
    property p_addr_first;
        $rose(dbg_active) |-> !data_phase;
    endproperty
    a_addr_first: assert property (p_addr_first) else $error("not address phase");
    property p_toggle;
        $changed(data_phase) && !$past(upd_ir) |-> $past(upd_dr) && !$past(busy);
    endproperty
    a_toggle: assert property (p_toggle) else $error("bad phase toggle");
    property p_launch;
        sab_req.valid |-> $past(upd_dr) ##1 busy [*2];
    endproperty
    a_launch: assert property (p_launch) else $error("launch without update");
    property p_rd_capture;
        cap_dr && rd_capture |=> dr_sr[DR_W-1] == $past(err) && dr_sr[DR_W-2] == $past(busy);
    endproperty
    a_rd_capture: assert property (p_rd_capture) else $error("bad status capture");
    property p_err;
        busy && sab_rsp.done && !launch |=> !busy && err == $past(sab_rsp.err);
    endproperty
    a_err: assert property (p_err) else $error("error not reported");
    property p_oe;
        tck_fall && st != ST_SH_DR && st != ST_SH_IR |=> !tdo_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("tdo driven outside shift");
endmodule : djr_top

//--- tb/djr_dbg.sv
// Scan debugger model: moves the test access port pins from tasks.
// Assumes aclk from the bench; the scan clock runs only within frames.
`timescale 1ns/1ps
module djr_dbg (
    input wire logic aclk, // Pacing clock
    output logic tck, // Scan clock
    output logic tms, // Scan mode select
    output logic tdi, // Scan data out to block
    input wire logic tdo // Scan data from block
);
    // Idle pins, clock stands low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One 32 ns scan clock; call just after an aclk edge, tdo taken before the rise
    task automatic step(input logic m, input logic v, output logic q);
        tms <= m;
        tdi <= v;
        repeat (4) @(posedge aclk);
        q = tdo;
        tck <= 1'b1;
        repeat (4) @(posedge aclk);
        tck <= 1'b0;
    endtask : step

    // Five ones reach Test-Logic-Reset, then idle
    task automatic reset;
        logic q;
        repeat (5) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask : reset

    // Idle to idle scan of n bits; unused bits left toggling
    task automatic scan(input logic ir, input int n, input logic [33:0] din,
                        output logic [33:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi, q);
        if (ir) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask : scan
endmodule : djr_dbg

//--- tb/djr_top_tb.sv
// Bench for the debug register access scan block.
// Assumes the debugger model djr_dbg; the bus responder lives here.
`timescale 1ns/1ps
module djr_top_tb;
    import djr_pkg::*;
    logic aclk, aresetn, tck, tms, tdi, tdo, tdo_oe, fuse_secure, hold, rsp_err;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rsp_data, d;
    logic [1:0] bresp, rresp, r;
    logic [33:0] so;
    djr_sab_req_t req, last_req;
    djr_sab_rsp_t rsp;
    int n_req, wait_cnt, miscompares, checked;

    djr_top uut (.aclk(aclk), .aresetn(aresetn), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .fuse_secure(fuse_secure), .sab_req(req), .sab_rsp(rsp),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    djr_dbg dbg (.aclk(aclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    // System clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Bus responder: answers three cycles on unless held
    always @(posedge aclk) begin
        rsp.done <= !req.valid && wait_cnt == 1 && !hold;
        if (req.valid) begin
            last_req <= req;
            n_req <= n_req + 1;
            wait_cnt <= 3;
        end else if (wait_cnt == 1 && !hold) begin
            rsp.err <= rsp_err;
            rsp.rdata <= rsp_data;
            wait_cnt <= 0;
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end
    end

    // Compare and count
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            $display("Error at %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    // Register write over the bus
    task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : axw

    // Register read over the bus
    task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axr

    // Let any launch land, then count requests
    task automatic wreq(input int n);
        repeat (20) @(posedge aclk);
        chk(34'(n_req), 34'(n));
    endtask : wreq

    task automatic t_ir;
        dbg.scan(1'b1, 5, 34'(IR_DBG), so);
        fork
            dbg.scan(1'b1, 5, 34'(IR_DBG), so);
            begin
                repeat (50) @(posedge aclk);
                chk(tdo_oe, 1'b1);
            end
        join
        chk(so[4:0], 5'b00001);
        chk(tdo_oe, 1'b0);
        axr(OFF_STAT, d, r);
        chk(d[1:0], 2'b01);
        $display("t_ir done");
    endtask : t_ir

    task automatic t_read;
        int b;
        logic [6:0] ix;
        logic [33:0] m;
        b = n_req;
        for (int k = 0; k < 2; k++) begin
            ix = k ? 7'h55 : 7'h2a;
            m = k ? 34'h0_0000_ffff : 34'h3_ffff_ffff;
            rsp_data <= k ? 32'h1234_5678 : 32'ha5c3_0f96;
            dbg.scan(1'b0, 8, {26'h0, ix, 1'b1}, so);
            wreq(b + k + 1);
            chk(last_req.rnw, 1'b1);
            chk(last_req.index, ix);
            dbg.scan(1'b0, k ? 16 : 34, 34'h0, so);
            chk(so & m, {2'b00, rsp_data} & m);
            axr(OFF_STAT, d, r);
            chk(d[1], 1'b0);
        end
        $display("t_read done");
    endtask : t_read

    task automatic t_write;
        int b;
        b = n_req;
        rsp_err <= 1'b1;
        dbg.scan(1'b0, 34, {26'h3ff_ffff, 7'h11, 1'b0}, so);
        wreq(b);
        dbg.scan(1'b0, 34, {2'b11, 32'h0f1e_2d3c}, so);
        wreq(b + 1);
        chk(last_req.rnw, 1'b0);
        chk(last_req.index, 7'h11);
        chk(last_req.wdata, 32'h0f1e_2d3c);
        dbg.scan(1'b1, 5, 34'(IR_DBG), so);
        chk(so[4:0], 5'b01001);
        rsp_err <= 1'b0;
        $display("t_write done");
    endtask : t_write

    task automatic t_busy;
        int b;
        b = n_req;
        hold <= 1'b1;
        rsp_data <= 32'h9e37_79b9;
        dbg.scan(1'b0, 8, {26'h0, 7'h05, 1'b1}, so);
        wreq(b + 1);
        dbg.scan(1'b0, 34, 34'h0, so);
        chk(so[32], 1'b1);
        axr(OFF_STAT, d, r);
        chk(d[2:1], 2'b11);
        hold <= 1'b0;
        dbg.scan(1'b0, 34, 34'h0, so);
        chk(so, {2'b00, 32'h9e37_79b9});
        wreq(b + 1);
        $display("t_busy done");
    endtask : t_busy

    task automatic t_prot;
        int b;
        b = n_req;
        axw(OFF_CTRL, 32'h0000_0001, r);
        chk(r, RESP_OKAY);
        dbg.scan(1'b1, 5, 34'(IR_DBG), so);
        dbg.scan(1'b1, 5, 34'(IR_DBG), so);
        chk(so[4:0], 5'b10001);
        dbg.scan(1'b0, 8, 34'h0_0000_00b4, so);
        chk(so[7:0], 8'h68);
        wreq(b);
        axr(4'h8, d, r);
        chk(r, RESP_SLVERR);
        chk(d, WORD_ZERO);
        axw(OFF_CTRL, WORD_ZERO, r);
        fuse_secure <= 1'b1;
        dbg.scan(1'b1, 5, 34'(IR_DBG), so);
        chk(so[4:0], 5'b10001);
        fuse_secure <= 1'b0;
        $display("t_prot done");
    endtask : t_prot

    // Verdict and end of run
    task automatic stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // Watchdog, several times the expected run length
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        stop_test();
    end

    // Reset, then the scenarios
    initial begin
        {aresetn, fuse_secure, hold, rsp_err, awvalid, wvalid, bready} = '0;
        {arvalid, rready, awaddr, araddr, wdata, rsp_data} = '0;
        rsp = '0;
        {n_req, wait_cnt, miscompares, checked} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        dbg.reset();
        t_ir();
        t_read();
        t_write();
        t_busy();
        t_prot();
        stop_test();
    end
endmodule : djr_top_tb
